// file: pin_bank_two_pkg.sv
// Purpose: Shared constants for the second analog pin bank multiplexer.
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register.
// Notes:   Pin order is A0 A2 A3 A4 A6 A7 B0 B2 B3 B4 B6 B7.
package pin_bank_two_pkg;

   // ==========================================================
   // Geometry
   localparam int PIN_COUNT  = 12;
   localparam int LINE_COUNT = 6;
   localparam int ADR_W      = 8;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ROUTE_OFS = 8'h00;
   localparam logic [7:0] DATA_OFS  = 8'h04;
   localparam logic [7:0] DIR_OFS   = 8'h08;

   // ==========================================================
   // Reset values and field layout
   // All odd select bits set: every pin starts on its analog path
   localparam logic [31:0] ROUTE_RESET = 32'haaaaaaaa;
   localparam logic [31:0] ODD_MASK    = 32'haaaaaaaa;
   localparam logic [5:0]  DATA_RESET  = 6'h00;
   localparam logic [5:0]  DIR_RESET   = 6'h00;
   localparam logic [31:0] UNMAPPED_RD = 32'h00000000;

   // Converter channel (A0..A7 = 0..7, B0..B7 = 8..15) of each pin
   localparam int PIN_CHAN [PIN_COUNT] =
      '{0, 2, 3, 4, 6, 7, 8, 10, 11, 12, 14, 15};
   // Pin carrying each digital line 18, 20, 22, 26, 28, 30
   localparam int LINE_PIN [LINE_COUNT] = '{1, 3, 4, 7, 9, 10};

   // Bus answers one cycle after the request is seen
   localparam int ANSWER_CYCLES = 1;

   // Select bit of a converter channel is the odd bit above it
   function automatic int sel_bit(input int chan);
      return 2 * chan + 1;
   endfunction

   // Digital line of a pin, or -1 where digital mode is reserved
   function automatic int pin_line(input int pin);
      int r;
      r = -1;
      for (int d = 0; d < LINE_COUNT; d++) begin
         if (LINE_PIN[d] == pin) begin
            r = d;
         end
      end
      return r;
   endfunction

endpackage

// file: bank_bus_port.sv
// Purpose: Classic Wishbone handshake for the pin bank registers.
// Assumes: Master holds the request until ack or err is seen.
// Notes:   Answer always comes one cycle after the request.
`timescale 1ns/100ps
module bank_bus_port
   import pin_bank_two_pkg::*;
(
   input  wire logic ref_clk_i,
   input  wire logic reset_i,
   input  wire logic cyc_i,
   input  wire logic stb_i,
   input  wire logic master_cpu_i,
   output logic      ack_o,
   output logic      err_o,
   output logic      accept_o
);

   logic pending;

   // ==========================================================
   // Request detection
   // A request is seen once; the answer flop masks the held cycle
   assign pending  = cyc_i && stb_i && !ack_o && !err_o;
   assign accept_o = pending && !master_cpu_i;

   // ==========================================================
   // Answer flops
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= accept_o;
      end
   end

   // Master processor cycles are refused with err, nothing stored
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         err_o <= 1'b0;
      end else begin
         err_o <= pending && master_cpu_i;
      end
   end

endmodule

// file: bank_pin_cell.sv
// Purpose: Routing and digital driver for one pin of the bank.
// Assumes: Select and direction arrive from registers of the top.
// Notes:   Pins without a digital line stay analog whatever is set.
`timescale 1ns/100ps
module bank_pin_cell #(
   parameter bit HAS_LINE = 1'b1
) (
   input  wire logic ref_clk_i,
   input  wire logic reset_i,
   input  wire logic analog_sel_i,
   input  wire logic dir_out_i,
   input  wire logic data_i,
   input  wire logic line_in_i,
   output logic      analog_en_o,
   output logic      line_oe_o,
   output logic      line_out_o,
   output logic      line_rd_o
);

   logic digital_mode;

   // Reserved digital mode falls back to the analog path
   assign digital_mode = HAS_LINE && !analog_sel_i;

   // ==========================================================
   // Routing
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         analog_en_o <= 1'b1;
      end else begin
         analog_en_o <= !digital_mode;
      end
   end

   // ==========================================================
   // Digital driver, off whenever the pin is analog
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         line_oe_o  <= 1'b0;
         line_out_o <= 1'b0;
      end else begin
         line_oe_o  <= digital_mode && dir_out_i;
         line_out_o <= digital_mode && data_i;
      end
   end

   // Readback hides the pad level while the pin is analog
   assign line_rd_o = !analog_en_o && line_in_i;

endmodule

// file: analog_pin_bank_two.sv
// Purpose: Second analog pin bank: twelve pins, analog path or digital
//          line, steered by odd bits of the route select register.
// Assumes: Only the control processor may touch the registers; the
//          master processor is flagged on master_cpu_i.
// Notes:   Registers: route select 0x00, line data 0x04, direction
//          0x08. Pin analog_en drives the pad switch of the converter
//          and comparator input; which of the two is live is up to
//          those peripherals.
//
// Behaviour
// - After reset every pin is analog and every digital driver is off.
// - An odd select bit at 0 connects the pin to its digital line.
// - An odd select bit at 1 routes the pin to converter or comparator.
// - Even select bits are ignored and written values are dropped.
// - Bit 9 selects pin A4 between line twenty and the analog path.
// - Only A2 A4 A6 B2 B4 B6 carry lines; elsewhere digital is reserved.
// - Digital lines have no pull-up control at all.
// - Registers read and write six line values and per-line direction.
// - Only the control processor reaches these registers; master is refused.
// - This bank has its own register set, separate from bank one.
// - Route select picks among twelve analog inputs and six lines.
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module analog_pin_bank_two
   import pin_bank_two_pkg::*;
#(
   parameter int PINS  = PIN_COUNT,
   parameter int LINES = LINE_COUNT
) (
   input  wire logic              ref_clk_i,
   input  wire logic              reset_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   input  wire logic              master_cpu_i,
   input  wire logic [LINES-1:0]  line_in_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   output logic                   wb_err_o,
   output logic      [PINS-1:0]   pin_analog_en_o,
   output logic      [LINES-1:0]  line_out_o,
   output logic      [LINES-1:0]  line_oe_o
);

   // ==========================================================
   // Elaboration checks
   // The channel and line tables are fixed to this bank's wiring
   if (PINS != PIN_COUNT || LINES != LINE_COUNT) begin : g_bad_size
      $error("pin bank two supports 12 pins and 6 lines only");
   end

   logic              accept;
   logic              wr_en;
   logic              rd_en;
   logic [31:0]       route_reg;
   logic [31:0]       route_next;
   logic [LINES-1:0]  data_reg;
   logic [LINES-1:0]  data_next;
   logic [LINES-1:0]  dir_reg;
   logic [LINES-1:0]  dir_next;
   logic [PINS-1:0]   pin_oe;
   logic [PINS-1:0]   pin_out;
   logic [PINS-1:0]   pin_rd;
   logic [LINES-1:0]  line_rd;
   logic [LINES-1:0]  line_analog;
   logic [LINES-1:0]  line_sel_dig;
   logic [31:0]       rd_word;
   logic              taken;
   logic [31:0]       data_wide;
   logic [31:0]       dir_wide;

   // Byte-lane merge used by every writable register
   function automatic logic [31:0] lane_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  sel
   );
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   // ==========================================================
   // Bus port
   bank_bus_port u_bus (
      .ref_clk_i    (ref_clk_i),
      .reset_i      (reset_i),
      .cyc_i        (wb_cyc_i),
      .stb_i        (wb_stb_i),
      .master_cpu_i (master_cpu_i),
      .ack_o        (wb_ack_o),
      .err_o        (wb_err_o),
      .accept_o     (accept)
   );

   // Writes land on the edge at which the master samples ack, so a
   // cycle abandoned before its answer stores nothing
   assign wr_en = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
   assign rd_en = accept && !wb_we_i;
   assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

   // ==========================================================
   // Register set of this bank only
   // Even bits never store, so they cannot leak into routing
   assign route_next = lane_merge(route_reg, wb_dat_i, wb_sel_i)
                       & ODD_MASK;
   // Upper bits of data and direction never store and read as zero
   assign data_wide  = lane_merge({26'h0, data_reg}, wb_dat_i, wb_sel_i);
   assign dir_wide   = lane_merge({26'h0, dir_reg}, wb_dat_i, wb_sel_i);
   assign data_next  = data_wide[LINES-1:0];
   assign dir_next   = dir_wide[LINES-1:0];

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         route_reg <= ROUTE_RESET;
      end else if (wr_en && wb_adr_i == ROUTE_OFS) begin
         route_reg <= route_next;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         data_reg <= DATA_RESET;
      end else if (wr_en && wb_adr_i == DATA_OFS) begin
         data_reg <= data_next;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         dir_reg <= DIR_RESET;
      end else if (wr_en && wb_adr_i == DIR_OFS) begin
         dir_reg <= dir_next;
      end
   end

   // ==========================================================
   // Read path
   always_comb begin
      if (wb_adr_i == ROUTE_OFS) begin
         rd_word = route_reg;
      end else if (wb_adr_i == DATA_OFS) begin
         rd_word = {26'h0, line_rd};
      end else if (wb_adr_i == DIR_OFS) begin
         rd_word = {26'h0, dir_reg};
      end else begin
         rd_word = UNMAPPED_RD;
      end
   end

   // Zero on every taken write or refused cycle: nothing leaks to master
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (rd_en) begin
         wb_dat_o <= rd_word;
      end else if (taken) begin
         wb_dat_o <= 32'h00000000;
      end
   end

   // ==========================================================
   // Pin cells
   // No pull-up enable exists anywhere on these lines
   for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
      localparam int LN  = pin_line(p);
      localparam int LI  = (LN < 0) ? 0 : LN;
      localparam bit HAS = (LN >= 0);
      localparam int SB  = sel_bit(PIN_CHAN[p]);

      bank_pin_cell #(
         .HAS_LINE (HAS)
      ) u_cell (
         .ref_clk_i    (ref_clk_i),
         .reset_i      (reset_i),
         .analog_sel_i (route_reg[SB]),
         .dir_out_i    (HAS && dir_reg[LI]),
         .data_i       (HAS && data_reg[LI]),
         .line_in_i    (HAS && line_in_i[LI]),
         .analog_en_o  (pin_analog_en_o[p]),
         .line_oe_o    (pin_oe[p]),
         .line_out_o   (pin_out[p]),
         .line_rd_o    (pin_rd[p])
      );
   end

   for (genvar d = 0; d < LINE_COUNT; d++) begin : g_line
      localparam int LP = LINE_PIN[d];
      assign line_oe_o[d]    = pin_oe[LP];
      assign line_out_o[d]   = pin_out[LP];
      assign line_rd[d]      = pin_rd[LP];
      assign line_analog[d]  = pin_analog_en_o[LP];
      assign line_sel_dig[d] = !route_reg[sel_bit(PIN_CHAN[LP])];
   end

   // ==========================================================
   // Assertions
   localparam logic [11:0] LINE_PIN_MASK = 12'h69a;

   reset_analog_a: assert property (@(posedge ref_clk_i)
      $past(reset_i) |-> (&pin_analog_en_o) && line_oe_o == '0)
      else $error("pins not analog after reset");

   line20_digital_a: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      !route_reg[9] |=> !pin_analog_en_o[3])
      else $error("pin A4 not digital with bit 9 clear");

   line20_analog_a: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      route_reg[9] |=> pin_analog_en_o[3] && !line_oe_o[1])
      else $error("pin A4 not analog with bit 9 set");

   even_bits_a: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      (route_reg & ~ODD_MASK) == 32'h00000000)
      else $error("even select bit stored");

   reserved_pins_a: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      ##1 (pin_analog_en_o | LINE_PIN_MASK) == 12'hfff)
      else $error("pin without line left analog path");

   master_refused_a: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && master_cpu_i)
      |=> wb_err_o && !wb_ack_o && $stable(route_reg)
          && $stable(dir_reg) && $stable(data_reg))
      else $error("master processor access not refused");

   answer_time_a: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !master_cpu_i)
      |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not one cycle after request");

   analog_reads_zero_a: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      (rd_en && wb_adr_i == DATA_OFS)
      |=> (wb_dat_o[5:0] & $past(line_analog)) == 6'h00)
      else $error("analog pin read back nonzero");

   drive_follows_dir_a: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      ##1 line_oe_o == $past(dir_reg & line_sel_dig))
      else $error("line driver disagrees with direction");

   refused_data_zero_a: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      wb_err_o |-> wb_dat_o == 32'h00000000 && !wb_ack_o)
      else $error("refused access returned data");

   analog_quiet_a: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      ((line_oe_o | line_out_o) & line_analog) == 6'h00)
      else $error("analog pin driven digitally");

   line_read_a: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      (rd_en && wb_adr_i == DATA_OFS)
      |=> wb_dat_o == {26'h0, $past(line_in_i & ~line_analog)})
      else $error("line read disagrees with pad level");

   dir_write_a: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      (wr_en && wb_adr_i == DIR_OFS && wb_sel_i[0])
      |=> dir_reg == $past(wb_dat_i[LINES-1:0]))
      else $error("direction write did not land");

   ack_err_apart_a: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      !(wb_ack_o && wb_err_o))
      else $error("ack and err raised together");

   digital_write_c: cover property (@(posedge ref_clk_i)
      disable iff (reset_i)
      wr_en && wb_adr_i == ROUTE_OFS ##2 !pin_analog_en_o[3]);

   reserved_kept_c: cover property (@(posedge ref_clk_i)
      disable iff (reset_i)
      !route_reg[1] && pin_analog_en_o[0]);

   line_read_c: cover property (@(posedge ref_clk_i)
      disable iff (reset_i)
      rd_en && wb_adr_i == DATA_OFS && line_rd != 6'h00);

   line_driven_c: cover property (@(posedge ref_clk_i)
      disable iff (reset_i)
      line_oe_o[1] && line_out_o[1]);

   master_err_c: cover property (@(posedge ref_clk_i)
      disable iff (reset_i)
      wb_err_o);

endmodule

// file: tb_analog_pin_bank_two.sv
// Purpose: Self-checking bench for the second analog pin bank.
// Assumes: Wishbone answer comes within a few cycles; no pull-ups.
// Notes:   Each scenario task drives the bus; all but t_master and t_unmapped also judge the pins.
`timescale 1ns/100ps
module tb_analog_pin_bank_two;
   import pin_bank_two_pkg::*;

   // ==========================================================
   // Signals and instance
   logic        ref_clk_i;
   logic        reset_i;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i;
   logic        master_cpu_i;
   logic [5:0]  line_in_i;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        wb_err_o;
   logic [11:0] pin_analog_en_o;
   logic [5:0]  line_out_o;
   logic [5:0]  line_oe_o;
   int          bad_count;
   int          compares;

   analog_pin_bank_two analog_pin_bank_two_i (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .master_cpu_i(master_cpu_i), .line_in_i(line_in_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .pin_analog_en_o(pin_analog_en_o), .line_out_o(line_out_o),
      .line_oe_o(line_oe_o));

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   // ==========================================================
   // Shared tasks
   task automatic end_sim;
      if (bad_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // One classic cycle; request held until ack or err is sampled
   task automatic xfer(input logic we, input logic [7:0] adr,
                       input logic [31:0] dat, input logic [3:0] sel,
                       input logic mst, output logic [31:0] rd,
                       output logic er);
      int   n;
      logic seen;
      n = 0;
      seen = 1'b0;
      @(posedge ref_clk_i);
      wb_cyc_i     <= 1'b1;
      wb_stb_i     <= 1'b1;
      wb_we_i      <= we;
      wb_adr_i     <= adr;
      wb_sel_i     <= sel;
      wb_dat_i     <= dat;
      master_cpu_i <= mst;
      while (n < 20 && !seen) begin
         @(posedge ref_clk_i);
         n++;
         seen = (wb_ack_o === 1'b1 || wb_err_o === 1'b1);
      end
      rd = wb_dat_o;
      er = wb_err_o;
      wb_cyc_i     <= 1'b0;
      wb_stb_i     <= 1'b0;
      wb_we_i      <= 1'b0;
      master_cpu_i <= 1'b0;
      if (!seen) begin
         bad_count++;
         end_sim();
      end
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel);
      logic [31:0] rd;
      logic        er;
      xfer(1'b1, adr, dat, sel, 1'b0, rd, er);
      chk({31'h0, er}, 32'h0);
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      logic        er;
      xfer(1'b0, adr, 32'h0, 4'hf, 1'b0, rd, er);
      chk(rd, exp);
   endtask

   // Registers land on the ack edge, outputs one edge later; look just after it
   task automatic pins(input logic [11:0] an, input logic [5:0] oe,
                       input logic [5:0] out);
      @(posedge ref_clk_i);
      #1;
      chk({8'h00, pin_analog_en_o, line_oe_o, line_out_o},
          {8'h00, an, oe, out});
   endtask

   // ==========================================================
   // Scenarios
   // Converter and comparator enables live outside this block, so
   // no scenario turns on two destinations of one pin
   task automatic t_reset;
      line_in_i <= 6'h3f;
      pins(12'hfff, 6'h00, 6'h00);
      rd_chk(ROUTE_OFS, ROUTE_RESET);
      rd_chk(DATA_OFS, 32'h0);
      rd_chk(DIR_OFS, 32'h0);
   endtask

   task automatic t_even;
      wr(ROUTE_OFS, 32'hffffffff, 4'hf);
      rd_chk(ROUTE_OFS, 32'haaaaaaaa);
      pins(12'hfff, 6'h00, 6'h00);
      wr(ROUTE_OFS, 32'h55555555, 4'hf);
      rd_chk(ROUTE_OFS, 32'h0);
      pins(12'h965, 6'h00, 6'h00);
   endtask

   task automatic t_each;
      logic [11:0] exp;
      for (int p = 0; p < 12; p++) begin
         exp = 12'hfff;
         for (int d = 0; d < 6; d++) begin
            if (LINE_PIN[d] == p) exp[p] = 1'b0;
         end
         wr(ROUTE_OFS, ~(32'h1 << (2 * PIN_CHAN[p] + 1)), 4'hf);
         pins(exp, 6'h00, 6'h00);
      end
   endtask

   task automatic t_lines;
      @(posedge ref_clk_i);
      line_in_i <= 6'h33;
      wr(ROUTE_OFS, 32'h0, 4'hf);
      wr(DIR_OFS, 32'h17, 4'hf);
      wr(DATA_OFS, 32'h2a, 4'hf);
      pins(12'h965, 6'h17, 6'h2a);
      rd_chk(DATA_OFS, 32'h33);
      rd_chk(DIR_OFS, 32'h17);
      wr(ROUTE_OFS, 32'haaaaa8aa, 4'hf);
      pins(12'hff7, 6'h02, 6'h02);
      rd_chk(DATA_OFS, 32'h02);
   endtask

   task automatic t_bytes;
      wr(ROUTE_OFS, 32'haaaaaaaa, 4'hf);
      wr(ROUTE_OFS, 32'h0, 4'h1);
      rd_chk(ROUTE_OFS, 32'haaaaaa00);
      pins(12'hffd, 6'h01, 6'h00);
   endtask

   task automatic t_master;
      logic [31:0] rd;
      logic        er;
      xfer(1'b1, ROUTE_OFS, 32'h0, 4'hf, 1'b1, rd, er);
      chk({31'h0, er}, 32'h1);
      rd_chk(ROUTE_OFS, 32'haaaaaa00);
      xfer(1'b0, ROUTE_OFS, 32'h0, 4'hf, 1'b1, rd, er);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      rd_chk(ROUTE_OFS, 32'haaaaaa00);
   endtask

   task automatic t_unmapped;
      wr(8'h0c, 32'hffffffff, 4'hf);
      rd_chk(8'h0c, 32'h0);
      rd_chk(ROUTE_OFS, 32'haaaaaa00);
   endtask

   task automatic t_rereset;
      @(posedge ref_clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      pins(12'hfff, 6'h00, 6'h00);
      rd_chk(ROUTE_OFS, ROUTE_RESET);
      rd_chk(DIR_OFS, 32'h0);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      bad_count    = 0;
      compares     = 0;
      reset_i      = 1'b1;
      wb_cyc_i     = 1'b0;
      wb_stb_i     = 1'b0;
      wb_we_i      = 1'b0;
      wb_adr_i     = 8'h00;
      wb_sel_i     = 4'h0;
      wb_dat_i     = 32'h0;
      master_cpu_i = 1'b0;
      line_in_i    = 6'h00;
      repeat (3) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      t_reset();
      t_even();
      t_each();
      t_lines();
      t_bytes();
      t_master();
      t_unmapped();
      t_rereset();
      end_sim();
   end
endmodule
